/* File: rtl/crb_consts.svh */
// Purpose: constants for the control register block
// Assumes: register indices as printed; byte address is four times index
// Notes: timing counts derived from a 100 MHz clock
`ifndef CRB_CONSTS_SVH
`define CRB_CONSTS_SVH

// register indices
`define CRB_IDX_SIG 4'h0
`define CRB_IDX_LOCK 4'h4
`define CRB_IDX_INIT 4'h5
`define CRB_IDX_MISC 4'h6
`define CRB_IDX_GPO 4'h7
`define CRB_IDX_OUT 4'h8
// lock keys
`define CRB_KEY_LOCK 8'hcb
`define CRB_KEY_UNLOCK 8'h34
// init register fields
`define CRB_INIT_REINIT 0
`define CRB_INIT_ALIGN 1
`define CRB_INIT_ODRST 2
// misc register fields
`define CRB_MISC_CHECK 0
`define CRB_MISC_BIAS 2
`define CRB_MISC_VCO 3
// reset values
`define CRB_RST_SIG 32'h0000_0000
`define CRB_RST_BYTE 8'h00
`define CRB_RST_OUT 16'h1000
`define CRB_OUT_MASK 16'h1fff
// squelch time for divider alignment
`define CRB_SQUELCH_NS 10000
`define CRB_CLK_NS 10
`define CRB_SQUELCH_CYC ((`CRB_SQUELCH_NS + `CRB_CLK_NS - 1) / `CRB_CLK_NS)

`endif

/* File: rtl/crb_pkg.sv */
// Purpose: types for the control register block
// Assumes: nothing
// Notes: constants live in crb_consts.svh
package crb_pkg;
  typedef enum logic [2:0] {CRB_IDLE, CRB_VCO_CAL, CRB_ALIGN_WAIT,
    CRB_ALIGN, CRB_DONE} crb_seq_t;
endpackage

/* File: rtl/crb_squelch_timer.sv */
// Purpose: counts the output squelch interval of divider alignment
// Assumes: start is a one-cycle pulse
// Notes: restart while busy reloads the count
`timescale 1ns/1ns
`default_nettype none
module crb_squelch_timer #(
  parameter int unsigned CYCLES = 1000
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_start,
  output logic o_busy,
  output logic o_done
);
  logic [15:0] count;
  logic busy;
  logic done;

  // down counter, done pulses in the first cycle after busy falls
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      count <= 16'h0000;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else if (i_start)
    begin
      count <= 16'(CYCLES - 1);
      busy <= 1'b1;
      done <= 1'b0;
    end
    else if (busy)
    begin
      count <= count - 16'h0001;
      busy <= (count != 16'h0000);
      done <= (count == 16'h0000);
    end
    else
    begin
      done <= 1'b0;
    end
  end

  assign o_busy = busy;
  assign o_done = done;
endmodule // crb_squelch_timer
`default_nettype wire

/* File: rtl/crb_control_regs.sv */
// Purpose: control register group of a clock generator
// Assumes: plain register port; read data one cycle after read strobe
// Notes: calibration and signature engine sit outside, via handshake ports
// Contract
// - hold 32-bit expected signature compared against computed CRC-32
// - mismatch sets reload or fail event, chosen by error policy
// - lock key 0xCB sets config write protect
// - lock key 0x34 clears config write protect
// - output driver reset bit holds all drivers reset and disabled
// - alignment done indication is inverse of output driver reset
// - writing 1 to alignment bit aligns dividers; 0 does nothing
// - output clocks squelched about 10us during alignment
// - alignment bit self-clears when alignment finishes
// - PLL restart reruns sequence from VCO calibration, then alignment
// - PLL restart bit self-clears when whole sequence finishes
// - writing 1 over a stored 0 to VCO trigger starts VCO recalibration
// - writing 1 over a stored 0 to bias trigger starts bias recalibration
// - check trigger starts check unless automatic check running; self-clears
// - seven output level bits drive pins configured as general output
`include "crb_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module crb_control_regs (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // signature engine
  input wire logic i_sig_done,
  input wire logic [31:0] i_sig_calc,
  input wire logic i_sig_auto_busy,
  input wire logic i_sig_err_mode,
  output logic o_sig_check_start,
  output logic [31:0] o_sig_expected,
  output logic o_sig_reload_evt,
  output logic o_sig_fail_evt,
  // calibration handshakes
  output logic o_vco_cal_start,
  input wire logic i_vco_cal_done,
  output logic o_bias_cal_start,
  // outputs and pins
  output logic o_config_write_protect,
  output logic o_out_drv_reset,
  output logic o_out_drv_enable,
  output logic o_align_done,
  output logic o_div_align,
  output logic o_squelch,
  output logic [12:0] o_out_ctrl,
  input wire logic [6:0] i_gpio_is_output,
  output logic [6:0] o_gpio_level
);
  // -------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------
  logic [31:0] sig_exp;
  logic wp;
  logic out_rst;
  logic align_req;
  logic reinit_req;
  logic vco_trig;
  logic bias_trig;
  logic [6:0] gpo_lvl;
  logic [15:0] out_ctrl;
  logic [31:0] rdata;
  logic vco_start;
  logic bias_start;
  logic chk_start;
  logic reload_evt;
  logic fail_evt;
  crb_pkg::crb_seq_t seq;
  crb_pkg::crb_seq_t next_seq;

  // -------------------------------------------------------------------
  // decode
  // -------------------------------------------------------------------
  // register index compare
  function automatic logic hit(input logic [3:0] a, input logic [3:0] idx);
    hit = (a == idx);
  endfunction

  // written one over a stored zero: a fresh calibration request
  function automatic logic rise_on_write(input logic wr,
    input logic new_bit, input logic old_bit);
    rise_on_write = wr && new_bit && !old_bit;
  endfunction

  // write decode; protected registers are gated by the lock flag
  wire cfg_ok = !wp;
  wire wr_sig = i_wr && hit(i_addr, `CRB_IDX_SIG) && cfg_ok;
  wire wr_lock = i_wr && hit(i_addr, `CRB_IDX_LOCK);
  wire wr_init = i_wr && hit(i_addr, `CRB_IDX_INIT) && cfg_ok;
  wire wr_misc = i_wr && hit(i_addr, `CRB_IDX_MISC) && cfg_ok;
  wire wr_gpo = i_wr && hit(i_addr, `CRB_IDX_GPO) && cfg_ok;
  wire wr_out = i_wr && hit(i_addr, `CRB_IDX_OUT) && cfg_ok;

  // init request and lock key fields
  wire [7:0] wbyte = i_wdata[7:0];
  wire set_align = wr_init && wbyte[`CRB_INIT_ALIGN];
  wire set_reinit = wr_init && wbyte[`CRB_INIT_REINIT];
  wire key_lock = wr_lock && (wbyte == `CRB_KEY_LOCK);
  wire key_unlock = wr_lock && (wbyte == `CRB_KEY_UNLOCK);

  // -------------------------------------------------------------------
  // squelch timer
  // -------------------------------------------------------------------
  // timer starts in the state that pulses the divider align
  wire tmr_start = (seq == crb_pkg::CRB_ALIGN_WAIT);
  wire tmr_busy;
  wire tmr_done;

  crb_squelch_timer #(
    .CYCLES(`CRB_SQUELCH_CYC)
  ) u_timer (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_start(tmr_start),
    .o_busy(tmr_busy),
    .o_done(tmr_done)
  );

  // -------------------------------------------------------------------
  // init sequence
  // -------------------------------------------------------------------
  // next state of restart / alignment sequencer
  // a request landing while busy only sets its bit; no rerun
  always_comb
  begin
    next_seq = seq;
    case (seq)
      crb_pkg::CRB_IDLE:
      begin
        if (set_reinit)
          next_seq = crb_pkg::CRB_VCO_CAL;
        else if (set_align)
          next_seq = crb_pkg::CRB_ALIGN_WAIT;
      end
      crb_pkg::CRB_VCO_CAL:
      begin
        if (i_vco_cal_done)
          next_seq = crb_pkg::CRB_ALIGN_WAIT;
      end
      crb_pkg::CRB_ALIGN_WAIT:
        next_seq = crb_pkg::CRB_ALIGN;
      crb_pkg::CRB_ALIGN:
      begin
        if (tmr_done)
          next_seq = crb_pkg::CRB_DONE;
      end
      crb_pkg::CRB_DONE:
        next_seq = crb_pkg::CRB_IDLE;
      default:
        next_seq = crb_pkg::CRB_IDLE;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      seq <= crb_pkg::CRB_IDLE;
    else
      seq <= next_seq;
  end

  // request bits: set by write, cleared when sequence ends
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      align_req <= 1'b0;
      reinit_req <= 1'b0;
    end
    else
    begin
      if (set_align || set_reinit)
        align_req <= 1'b1;
      else if (seq == crb_pkg::CRB_DONE)
        align_req <= 1'b0;
      if (set_reinit)
        reinit_req <= 1'b1;
      else if (seq == crb_pkg::CRB_DONE)
        reinit_req <= 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // plain control registers
  // -------------------------------------------------------------------
  // expected signature, compared here against i_sig_calc
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      sig_exp <= `CRB_RST_SIG;
    else if (wr_sig)
      sig_exp <= i_wdata;
  end

  // configuration write protect, set and cleared by key only
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      wp <= 1'b0;
    else if (key_lock)
      wp <= 1'b1;
    else if (key_unlock)
      wp <= 1'b0;
  end

  // output driver reset level
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      out_rst <= 1'b0;
    else if (wr_init)
      out_rst <= wbyte[`CRB_INIT_ODRST];
  end

  // stored recalibration triggers, kept for edge detection
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      vco_trig <= 1'b0;
      bias_trig <= 1'b0;
    end
    else if (wr_misc)
    begin
      vco_trig <= wbyte[`CRB_MISC_VCO];
      bias_trig <= wbyte[`CRB_MISC_BIAS];
    end
  end

  // general output levels; bit 7 is not stored
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      gpo_lvl <= 7'h00;
    else if (wr_gpo)
      gpo_lvl <= wbyte[6:0];
  end

  // output control; reserved upper bits masked to zero
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      out_ctrl <= `CRB_RST_OUT;
    else if (wr_out)
      out_ctrl <= i_wdata[15:0] & `CRB_OUT_MASK;
  end

  // -------------------------------------------------------------------
  // triggers and signature events
  // -------------------------------------------------------------------
  // calibration edges, manual check request and mismatch
  wire vco_rise =
    rise_on_write(wr_misc, wbyte[`CRB_MISC_VCO], vco_trig);
  wire bias_rise =
    rise_on_write(wr_misc, wbyte[`CRB_MISC_BIAS], bias_trig);
  wire chk_req = wr_misc && wbyte[`CRB_MISC_CHECK] && !i_sig_auto_busy;
  wire mismatch = i_sig_done && (i_sig_calc != sig_exp);
  wire seq_vco = (seq == crb_pkg::CRB_IDLE) && set_reinit;

  // one-cycle start pulses to the calibrators and the check engine
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      vco_start <= 1'b0;
      bias_start <= 1'b0;
      chk_start <= 1'b0;
    end
    else
    begin
      vco_start <= vco_rise || seq_vco;
      bias_start <= bias_rise;
      chk_start <= chk_req;
    end
  end

  // mismatch event pulses, steered by the error policy
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      reload_evt <= 1'b0;
      fail_evt <= 1'b0;
    end
    else
    begin
      reload_evt <= mismatch && !i_sig_err_mode;
      fail_evt <= mismatch && i_sig_err_mode;
    end
  end

  // -------------------------------------------------------------------
  // read port
  // -------------------------------------------------------------------
  // read values; reserved and write-only fields read zero
  wire [7:0] init_rd = {5'h00, out_rst, align_req, reinit_req};
  wire [7:0] misc_rd = {4'h0, vco_trig, bias_trig, 2'h0};
  wire [31:0] rd_mux =
    hit(i_addr, `CRB_IDX_SIG) ? sig_exp :
    hit(i_addr, `CRB_IDX_INIT) ? {24'h00_0000, init_rd} :
    hit(i_addr, `CRB_IDX_MISC) ? {24'h00_0000, misc_rd} :
    hit(i_addr, `CRB_IDX_GPO) ? {25'h000_0000, gpo_lvl} :
    hit(i_addr, `CRB_IDX_OUT) ? {16'h0000, out_ctrl} :
    32'h0000_0000;

  // read data valid in the cycle after the strobe only
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      rdata <= 32'h0000_0000;
    else if (i_rd)
      rdata <= rd_mux;
    else
      rdata <= 32'h0000_0000;
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  // bus and signature engine
  assign o_rdata = rdata;
  assign o_sig_check_start = chk_start;
  assign o_sig_expected = sig_exp;
  assign o_sig_reload_evt = reload_evt;
  assign o_sig_fail_evt = fail_evt;

  // calibration starts and write protect
  assign o_vco_cal_start = vco_start;
  assign o_bias_cal_start = bias_start;
  assign o_config_write_protect = wp;

  // drivers, alignment and pin levels
  assign o_out_drv_reset = out_rst;
  assign o_out_drv_enable = !out_rst;
  assign o_align_done = !out_rst;
  assign o_div_align = tmr_start;
  assign o_squelch = tmr_busy;
  assign o_out_ctrl = out_ctrl[12:0];
  assign o_gpio_level = gpo_lvl & i_gpio_is_output;
endmodule // crb_control_regs
`default_nettype wire

/* File: bench/crb_asserts.sv */
// Purpose: port checks for crb_control_regs
// Assumes: one clock, sync active-low reset
// Notes: bound to the design below the module
`timescale 1ns/1ns
`default_nettype none
module crb_asserts (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_sig_done,
  input wire logic [31:0] i_sig_calc,
  input wire logic i_sig_err_mode,
  input wire logic i_sig_auto_busy,
  input wire logic o_sig_check_start,
  input wire logic [31:0] o_sig_expected,
  input wire logic o_sig_reload_evt,
  input wire logic o_sig_fail_evt,
  input wire logic o_config_write_protect,
  input wire logic o_out_drv_reset,
  input wire logic o_align_done,
  input wire logic o_div_align,
  input wire logic o_squelch
);
  // ------
  // checks
  // ------
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // decoded writes
  wire logic key_wr = i_wr && i_addr == 4'h4;
  wire logic sig_wr = i_wr && i_addr == 4'h0;
  a_sig_store: assert property (
    sig_wr && !o_config_write_protect |=> o_sig_expected == $past(i_wdata))
    else $error("signature not stored");
  a_sig_event: assert property (
    i_sig_done && i_sig_calc != o_sig_expected
    |=> ($past(i_sig_err_mode) ? o_sig_fail_evt : o_sig_reload_evt))
    else $error("mismatch event missing");
  a_key_lock: assert property (
    key_wr && i_wdata[7:0] == 8'hcb |=> o_config_write_protect)
    else $error("lock key did not protect");
  a_key_unlock: assert property (
    key_wr && i_wdata[7:0] == 8'h34 |=> !o_config_write_protect)
    else $error("unlock key did not clear");
  a_key_other: assert property (
    key_wr && i_wdata[7:0] != 8'hcb && i_wdata[7:0] != 8'h34
    |=> $stable(o_config_write_protect)) else $error("odd key changed lock");
  a_drv_reset: assert property (
    i_wr && i_addr == 4'h5 && !o_config_write_protect
    |=> o_out_drv_reset == $past(i_wdata[2]))
    else $error("driver reset not stored");
  a_done_inverse: assert property (
    o_align_done == !o_out_drv_reset) else $error("done not inverse");
  a_squelch_run: assert property (
    o_div_align |=> o_squelch [*8]) else $error("squelch not held");
  a_check_start: assert property (
    i_wr && i_addr == 4'h6 && i_wdata[0] && !i_sig_auto_busy
    && !o_config_write_protect |=> o_sig_check_start)
    else $error("check not started");
endmodule // crb_asserts
bind crb_control_regs crb_asserts u_chk (.*);
`default_nettype wire

/* File: bench/tb_crb_control_regs.sv */
// Purpose: self-checking bench for crb_control_regs
// Assumes: register port with read data one cycle after strobe
// Notes: squelch count is the fixed 1000 cycles
`timescale 1ns/1ns
`default_nettype none
module tb_crb_control_regs;
  logic i_clk, i_rst_n, i_wr, i_rd, i_sig_done, i_sig_auto_busy;
  logic i_sig_err_mode, i_vco_cal_done, o_sig_check_start;
  logic o_sig_reload_evt, o_sig_fail_evt, o_vco_cal_start;
  logic o_bias_cal_start, o_config_write_protect, o_out_drv_reset;
  logic o_out_drv_enable, o_align_done, o_div_align, o_squelch;
  logic [3:0] i_addr;
  logic [31:0] i_wdata, i_sig_calc, o_rdata, o_sig_expected, sig, rv;
  logic [6:0] i_gpio_is_output, o_gpio_level;
  logic [12:0] o_out_ctrl;
  int num_errors, n_checks, seed, k;
  crb_control_regs uut (.*);
  // -----------
  // bench tasks
  // -----------
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  // pin level expected from stored level and pin direction
  function automatic logic [31:0] exp_pin(logic [6:0] lvl, logic [6:0] dir);
    exp_pin = 32'(lvl & dir);
  endfunction
  // one write cycle, returns just after the taking edge
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  // one read cycle, data sampled in the cycle after the strobe
  task automatic rdc(logic [3:0] a, logic [31:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk("rdata", e, o_rdata);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // clock and watchdog
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial
  begin
    repeat (20000) @(posedge i_clk);
    num_errors++;
    summarize();
  end
  // ---------
  // scenarios
  // ---------
  initial
  begin
    seed = 98653;
    {i_rst_n, i_wr, i_rd, i_sig_done, i_sig_auto_busy} = 5'h00;
    {i_sig_err_mode, i_vco_cal_done, i_addr} = 6'h00;
    {i_wdata, i_sig_calc} = 64'h0000_0000_0000_0000;
    i_gpio_is_output = 7'h7f;
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    #1;
    chk("out_ctrl", 32'h0000_1000, o_out_ctrl);
    chk("drv_en", 32'h1, o_out_drv_enable);
    rdc(4'h8, 32'h0000_1000);
    rdc(4'h5, 32'h0);
    sig = $random(seed);
    wr(4'h0, sig);
    rdc(4'h0, sig);
    for (k = 0; k < 3; k++)
    begin
      @(posedge i_clk);
      i_sig_done <= 1'b1;
      i_sig_err_mode <= k[0];
      i_sig_calc <= (k == 2) ? sig : ~sig;
      @(posedge i_clk);
      i_sig_done <= 1'b0;
      #1;
      chk("reload", 32'(k == 0), o_sig_reload_evt);
      chk("fail", 32'(k == 1), o_sig_fail_evt);
    end
    wr(4'h4, 32'hcb);
    chk("protect", 32'h1, o_config_write_protect);
    wr(4'h0, ~sig);
    wr(4'h7, 32'h7f);
    rdc(4'h0, sig);
    rdc(4'h7, 32'h0);
    wr(4'h8, 32'h0);
    rdc(4'h8, 32'h0000_1000);
    rv = $random(seed);
    if (rv[7:0] == 8'hcb || rv[7:0] == 8'h34)
      rv[7:0] = 8'h00;
    wr(4'h4, {24'h00_0000, rv[7:0]});
    chk("protect", 32'h1, o_config_write_protect);
    wr(4'h4, 32'h34);
    chk("protect", 32'h0, o_config_write_protect);
    wr(4'h5, 32'hffff_fff8);
    rdc(4'h5, 32'h0);
    wr(4'h5, 32'h4);
    chk("drv_rst", 32'h1, o_out_drv_reset);
    chk("drv_en", 32'h0, o_out_drv_enable);
    chk("done", 32'h0, o_align_done);
    wr(4'h5, 32'h0);
    chk("div", 32'h0, o_div_align);
    wr(4'h5, 32'h2);
    chk("div", 32'h1, o_div_align);
    #10;
    for (k = 0; k < 1100 && o_squelch === 1'b1; k++) #10;
    chk("squelch", 32'd1000, k);
    rdc(4'h5, 32'h2);
    rdc(4'h5, 32'h0);
    wr(4'h5, 32'h1);
    chk("vco", 32'h1, o_vco_cal_start);
    @(posedge i_clk);
    i_vco_cal_done <= 1'b1;
    @(posedge i_clk);
    i_vco_cal_done <= 1'b0;
    #1;
    for (k = 0; k < 20 && o_div_align !== 1'b1; k++) #10;
    chk("div", 32'h1, o_div_align);
    #10;
    for (k = 0; k < 1100 && o_squelch === 1'b1; k++) #10;
    chk("squelch", 32'd1000, k);
    rdc(4'h5, 32'h3);
    rdc(4'h5, 32'h0);
    wr(4'h6, 32'h8);
    chk("vco", 32'h1, o_vco_cal_start);
    wr(4'h6, 32'h8);
    chk("vco", 32'h0, o_vco_cal_start);
    wr(4'h6, 32'h4);
    chk("bias", 32'h1, o_bias_cal_start);
    rdc(4'h6, 32'h4);
    i_sig_auto_busy <= 1'b1;
    wr(4'h6, 32'h1);
    chk("check", 32'h0, o_sig_check_start);
    i_sig_auto_busy <= 1'b0;
    wr(4'h6, 32'h1);
    chk("check", 32'h1, o_sig_check_start);
    for (k = 0; k < 8; k++)
    begin
      rv = $random(seed);
      i_gpio_is_output <= rv[14:8];
      wr(4'h7, rv);
      chk("gpo", exp_pin(rv[6:0], rv[14:8]), o_gpio_level);
      rdc(4'h7, 32'(rv[6:0]));
    end
    summarize();
  end
endmodule // tb_crb_control_regs
`default_nettype wire
